// [hdl/cis_pkg.sv]
package cis_pkg;
  // ---------------------------------------------------------------------------
  // Opcode encodings
  // ---------------------------------------------------------------------------
  localparam logic [15:0] CIS_CALL_VIA_W_CODE = 16'h0014;
  localparam logic [5:0] CIS_DEC_FILE_TOP = 6'h01;
  localparam int CIS_TOP_MSB = 15;
  localparam int CIS_TOP_LSB = 10;
  localparam int CIS_DEST_BIT = 9;
  localparam int CIS_BANK_BIT = 8;

  // ---------------------------------------------------------------------------
  // Addressing constants
  // ---------------------------------------------------------------------------
  localparam logic [7:0] CIS_INDEX_LIMIT = 8'h5f;
  localparam logic [7:0] CIS_ACCESS_SPLIT = 8'h60;
  localparam logic [3:0] CIS_ACCESS_LOW_BANK = 4'h0;
  localparam logic [3:0] CIS_ACCESS_HIGH_BANK = 4'hf;
  localparam logic [20:0] CIS_RETURN_STEP = 21'h000002;

  // ---------------------------------------------------------------------------
  // Status bit positions: C, DC, Z, OV, N
  // ---------------------------------------------------------------------------
  localparam int CIS_ST_C = 0;
  localparam int CIS_ST_DC = 1;
  localparam int CIS_ST_Z = 2;
  localparam int CIS_ST_OV = 3;
  localparam int CIS_ST_N = 4;

  // Execution phases of the sequencer
  typedef enum logic [2:0] {
    CIS_IDLE = 3'b001,
    CIS_EXEC = 3'b010,
    CIS_CALL_NOP = 3'b100
  } cis_state_type;
endpackage : cis_pkg

// [hdl/cis_dec_alu.sv]
`timescale 1ns/1ps
// Decrement datapath with full status generation
module cis_dec_alu (
  input wire logic [7:0] operand,
  output logic [7:0] result,
  output logic [4:0] flags
);
  import cis_pkg::*;

  // ---------------------------------------------------------------------------
  // Subtract one as operand + 0xff so borrow flags follow add-complement form
  // ---------------------------------------------------------------------------
  logic [8:0] sum;
  logic [4:0] lowSum;
  always_comb begin
    sum = {1'b0, operand} + 9'h0ff;
    lowSum = {1'b0, operand[3:0]} + 5'h0f;
    result = sum[7:0];
    flags = '0;
    flags[CIS_ST_C] = sum[8];
    flags[CIS_ST_DC] = lowSum[4];
    flags[CIS_ST_Z] = (sum[7:0] == 8'h00);
    flags[CIS_ST_OV] = (operand == 8'h80);
    flags[CIS_ST_N] = sum[7];
  end
endmodule : cis_dec_alu

// [hdl/cis_core.sv]
`timescale 1ns/1ps
// Operation
// - Bank bit 0: address lands in the fixed access bank, except extended set with operand up to 0x5F.
// - Bank bit 1: bank select register picks the register bank.
// - Bank bit 0, extended set, operand up to 0x5F: indexed offset addressing.
// - Register-indirect call first pushes program counter plus two.
// - It then loads the low counter byte from the working register.
// - It then copies high and upper latches into counter bytes.
// - A second cycle does nothing while the target is fetched.
// - No saving of working, status or bank registers.
module cis_core (
  input wire logic clock,
  input wire logic nrst,
  input wire logic instrValid,
  input wire logic [15:0] instrWord,
  input wire logic extendedEn,
  input wire logic [3:0] bankSelectReg,
  input wire logic [7:0] workingRegAlias,
  input wire logic [7:0] pcHighLatch,
  input wire logic [4:0] pcUpperLatch,
  input wire logic [20:0] pcCurrent,
  input wire logic [11:0] indirectPointerTwo,
  input wire logic [7:0] fileReadData,
  output logic [11:0] fileAddr,
  output logic [7:0] fileWriteData,
  output logic fileWriteEn,
  output logic [7:0] workingWriteData,
  output logic workingWriteEn,
  output logic [4:0] statusFlags,
  output logic statusWriteEn,
  output logic [20:0] pushAddr,
  output logic pushEn,
  output logic [20:0] pcLoad,
  output logic pcLoadEn,
  output logic busy
);
  import cis_pkg::*;

  // ---------------------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------------------
  logic isDecFile;
  logic isCall;
  logic [7:0] fOperand;
  logic [11:0] addrComb;
  logic [7:0] decResult;
  logic [4:0] decFlags;
  cis_state_type state_reg, state_next;

  // Words offered in the dead call slot are dropped, not queued
  assign isDecFile = instrValid && (state_reg != CIS_CALL_NOP)
    && (instrWord[CIS_TOP_MSB:CIS_TOP_LSB] == CIS_DEC_FILE_TOP);
  assign isCall = instrValid && (state_reg != CIS_CALL_NOP) && (instrWord == CIS_CALL_VIA_W_CODE);
  assign fOperand = instrWord[7:0];

  // Address resolution; indexed mode outranks plain access bank
  always_comb begin
    if (instrWord[CIS_BANK_BIT]) begin
      addrComb = {bankSelectReg, fOperand};
    end else if (extendedEn && (fOperand <= CIS_INDEX_LIMIT)) begin
      addrComb = indirectPointerTwo + {4'h0, fOperand};
    end else if (fOperand < CIS_ACCESS_SPLIT) begin
      addrComb = {CIS_ACCESS_LOW_BANK, fOperand};
    end else begin
      addrComb = {CIS_ACCESS_HIGH_BANK, fOperand};
    end
  end

  // Arithmetic lives in its own leaf so the flag logic stays testable alone
  cis_dec_alu uAlu (
    .operand(fileReadData),
    .result(decResult),
    .flags(decFlags)
  );

  // ---------------------------------------------------------------------------
  // Sequencer: call takes two cycles, the second is a dead fetch slot
  // ---------------------------------------------------------------------------
  always_comb begin
    state_next = CIS_IDLE;
    if (isCall) begin
      state_next = CIS_CALL_NOP;
    end else if (isDecFile) begin
      state_next = CIS_EXEC;
    end
  end

  // ---------------------------------------------------------------------------
  // Registered outputs; file read data is used with its instruction, a cycle before fileAddr shows the address
  // ---------------------------------------------------------------------------
  logic [11:0] fileAddr_reg, fileAddr_next;
  logic [7:0] fileData_reg, fileData_next;
  logic fileWe_reg, fileWe_next;
  logic [7:0] wData_reg, wData_next;
  logic wWe_reg, wWe_next;
  logic [4:0] flags_reg, flags_next;
  logic flagsWe_reg, flagsWe_next;
  logic [20:0] push_reg, push_next;
  logic pushEn_reg, pushEn_next;
  logic [20:0] pcLoad_reg, pcLoad_next;
  logic pcLoadEn_reg, pcLoadEn_next;
  logic busy_reg, busy_next;

  // Next values; the call never touches working, status or bank state
  always_comb begin
    fileAddr_next = addrComb;
    fileData_next = decResult;
    fileWe_next = 1'b0;
    wData_next = decResult;
    wWe_next = 1'b0;
    flags_next = flags_reg;
    flagsWe_next = 1'b0;
    push_next = push_reg;
    pushEn_next = 1'b0;
    pcLoad_next = pcLoad_reg;
    pcLoadEn_next = 1'b0;
    busy_next = isCall;
    if (isDecFile) begin
      fileWe_next = instrWord[CIS_DEST_BIT];
      wWe_next = !instrWord[CIS_DEST_BIT];
      flags_next = decFlags;
      flagsWe_next = 1'b1;
    end
    if (isCall) begin
      push_next = pcCurrent + CIS_RETURN_STEP;
      pushEn_next = 1'b1;
      pcLoad_next = {pcUpperLatch, pcHighLatch, workingRegAlias};
      pcLoadEn_next = 1'b1;
    end
  end

  // Plain registers only
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_reg <= CIS_IDLE;
      fileAddr_reg <= '0;
      fileData_reg <= '0;
      fileWe_reg <= 1'b0;
      wData_reg <= '0;
      wWe_reg <= 1'b0;
      flags_reg <= '0;
      flagsWe_reg <= 1'b0;
      push_reg <= '0;
      pushEn_reg <= 1'b0;
      pcLoad_reg <= '0;
      pcLoadEn_reg <= 1'b0;
      busy_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      fileAddr_reg <= fileAddr_next;
      fileData_reg <= fileData_next;
      fileWe_reg <= fileWe_next;
      wData_reg <= wData_next;
      wWe_reg <= wWe_next;
      flags_reg <= flags_next;
      flagsWe_reg <= flagsWe_next;
      push_reg <= push_next;
      pushEn_reg <= pushEn_next;
      pcLoad_reg <= pcLoad_next;
      pcLoadEn_reg <= pcLoadEn_next;
      busy_reg <= busy_next;
    end
  end

  assign fileAddr = fileAddr_reg;
  assign fileWriteData = fileData_reg;
  assign fileWriteEn = fileWe_reg;
  assign workingWriteData = wData_reg;
  assign workingWriteEn = wWe_reg;
  assign statusFlags = flags_reg;
  assign statusWriteEn = flagsWe_reg;
  assign pushAddr = push_reg;
  assign pushEn = pushEn_reg;
  assign pcLoad = pcLoad_reg;
  assign pcLoadEn = pcLoadEn_reg;
  assign busy = busy_reg;

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  sequence seqCallIssued;
    isCall;
  endsequence
  sequence seqCallDone;
    pushEn && pcLoadEn && busy;
  endsequence

  AST_BANK_SEL: assert property (@(posedge clock) disable iff (!nrst)
    isDecFile && instrWord[CIS_BANK_BIT] |=> fileAddr == {$past(bankSelectReg), $past(fOperand)})
    else $error("bank select address wrong");
  AST_ACCESS_LOW: assert property (@(posedge clock) disable iff (!nrst)
    isDecFile && !instrWord[CIS_BANK_BIT] && !extendedEn && fOperand < CIS_ACCESS_SPLIT
    |=> fileAddr[11:8] == CIS_ACCESS_LOW_BANK)
    else $error("access bank low address wrong");
  AST_ACCESS_HIGH: assert property (@(posedge clock) disable iff (!nrst)
    isDecFile && !instrWord[CIS_BANK_BIT] && fOperand >= CIS_ACCESS_SPLIT
    |=> fileAddr[11:8] == CIS_ACCESS_HIGH_BANK)
    else $error("access bank high address wrong");
  AST_INDEXED: assert property (@(posedge clock) disable iff (!nrst)
    isDecFile && !instrWord[CIS_BANK_BIT] && extendedEn && fOperand <= CIS_INDEX_LIMIT
    |=> fileAddr == $past(indirectPointerTwo) + {4'h0, $past(fOperand)})
    else $error("indexed address wrong");
  AST_PUSH: assert property (@(posedge clock) disable iff (!nrst)
    isCall |=> pushEn && pushAddr == $past(pcCurrent) + CIS_RETURN_STEP)
    else $error("return push wrong");
  AST_PC_LOW: assert property (@(posedge clock) disable iff (!nrst)
    isCall |=> pcLoad[7:0] == $past(workingRegAlias))
    else $error("low byte not from working register");
  AST_LATCH: assert property (@(posedge clock) disable iff (!nrst)
    isCall |=> pcLoad[20:8] == {$past(pcUpperLatch), $past(pcHighLatch)})
    else $error("latch copy wrong");
  AST_NOP_CYCLE: assert property (@(posedge clock) disable iff (!nrst)
    seqCallIssued ##1 seqCallDone |-> ##1 (!pushEn && !fileWriteEn && !workingWriteEn && !busy))
    else $error("second call cycle not idle");
  AST_NO_SAVE: assert property (@(posedge clock) disable iff (!nrst)
    isCall |=> !workingWriteEn && !statusWriteEn)
    else $error("call touched saved state");
  AST_DEST: assert property (@(posedge clock) disable iff (!nrst)
    isDecFile |=> statusWriteEn && (fileWriteEn != workingWriteEn)
      && fileWriteData == $past(fileReadData) - 8'h01)
    else $error("decrement write wrong");
endmodule : cis_core

// [bench/cpu_instruction_semantics_test.sv]
`timescale 1ns/1ps
module cpu_instruction_semantics_test;
  import cis_pkg::*;
  // ---------------------------------------------------------------------------
  // Stimulus and observed signals
  // ---------------------------------------------------------------------------
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic instrValid = 1'b0;
  logic [15:0] instrWord = 16'h0000;
  logic extendedEn = 1'b0;
  logic [3:0] bankSelectReg = 4'h0;
  logic [7:0] workingRegAlias = 8'h00;
  logic [7:0] pcHighLatch = 8'h00;
  logic [4:0] pcUpperLatch = 5'h00;
  logic [20:0] pcCurrent = 21'h000000;
  logic [11:0] indirectPointerTwo = 12'h000;
  logic [7:0] fileReadData = 8'h00;
  logic [11:0] fileAddr;
  logic [7:0] fileWriteData, workingWriteData;
  logic [4:0] statusFlags;
  logic [20:0] pushAddr, pcLoad;
  logic fileWriteEn, workingWriteEn, statusWriteEn, pushEn, pcLoadEn, busy;
  int err_count = 0;
  int check_count = 0;
  int cycles = 0;
  int expKind = 0;
  logic [11:0] expAddr;
  logic [7:0] expRes;
  logic [4:0] expFlags;
  logic expDest;
  logic [20:0] expPush, expLoad;
  logic [7:0] fVals [4] = '{8'h5f, 8'h60, 8'hff, 8'h00};
  logic [7:0] dVals [4] = '{8'h00, 8'h80, 8'h10, 8'h01};

  cis_core uut (.clock(clock), .nrst(nrst), .instrValid(instrValid), .instrWord(instrWord),
    .extendedEn(extendedEn), .bankSelectReg(bankSelectReg), .workingRegAlias(workingRegAlias),
    .pcHighLatch(pcHighLatch), .pcUpperLatch(pcUpperLatch), .pcCurrent(pcCurrent),
    .indirectPointerTwo(indirectPointerTwo), .fileReadData(fileReadData), .fileAddr(fileAddr),
    .fileWriteData(fileWriteData), .fileWriteEn(fileWriteEn), .workingWriteData(workingWriteData),
    .workingWriteEn(workingWriteEn), .statusFlags(statusFlags), .statusWriteEn(statusWriteEn),
    .pushAddr(pushAddr), .pushEn(pushEn), .pcLoad(pcLoad), .pcLoadEn(pcLoadEn), .busy(busy));

  // ---------------------------------------------------------------------------
  // Clock and hang guard
  // ---------------------------------------------------------------------------
  always #5 clock = ~clock;

  // Run needs under 270 cycles; ceiling leaves ample slack
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      err_count++;
      $display("wrong value at %0t: timeout", $time);
      complete_run();
    end
  end

  // ---------------------------------------------------------------------------
  // Compare, drive and report tasks
  // ---------------------------------------------------------------------------
  task automatic chk(input logic [20:0] got, input logic [20:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  // Drive one slot, check the answer to the previous slot, then model this one
  task automatic step(input logic v, input logic [15:0] w, input logic [7:0] data);
    logic [7:0] f;
    @(posedge clock);
    instrValid <= v;
    instrWord <= w;
    fileReadData <= data;
    extendedEn <= 1'($urandom);
    bankSelectReg <= 4'($urandom);
    workingRegAlias <= 8'($urandom);
    pcHighLatch <= 8'($urandom);
    pcUpperLatch <= 5'($urandom);
    pcCurrent <= 21'($urandom);
    indirectPointerTwo <= 12'($urandom);
    #1;
    if (expKind == 1) begin
      chk(21'(fileAddr), 21'(expAddr), "address");
      chk(21'({fileWriteEn, workingWriteEn, statusWriteEn}), 21'({expDest, ~expDest, 1'b1}), "enables");
      chk(21'(expDest ? fileWriteData : workingWriteData), 21'(expRes), "result");
      chk(21'(statusFlags), 21'(expFlags), "flags");
      chk(21'({pushEn, pcLoadEn, busy}), 21'h0, "dec strobes");
    end else if (expKind == 2) begin
      chk(21'({pushEn, pcLoadEn, busy}), 21'h7, "call strobes");
      chk(21'({fileWriteEn, workingWriteEn, statusWriteEn}), 21'h0, "call saves");
      chk(pushAddr, expPush, "return address");
      chk(pcLoad, expLoad, "target");
    end else begin
      chk(21'({pushEn, pcLoadEn, fileWriteEn, workingWriteEn, statusWriteEn, busy}), 21'h0, "idle strobes");
    end
    // The slot right after a taken call is the dead cycle: nothing may answer
    expKind = (!v || expKind == 2) ? 0 : (w === CIS_CALL_VIA_W_CODE) ? 2 : 1;
    f = w[7:0];
    // Bank bit set, then indexed window, then split access bank
    if (w[CIS_BANK_BIT])
      expAddr = {bankSelectReg, f};
    else if (extendedEn && f <= 8'h5f)
      expAddr = indirectPointerTwo + 12'(f);
    else
      expAddr = {(f < 8'h60) ? 4'h0 : 4'hf, f};
    expRes = data - 8'h01;
    expFlags = {expRes[7], data == 8'h80, expRes == 8'h00, data[3:0] != 4'h0, data != 8'h00};
    expDest = w[CIS_DEST_BIT];
    expPush = pcCurrent + 21'h000002;
    expLoad = {pcUpperLatch, pcHighLatch, workingRegAlias};
  endtask : step

  task automatic complete_run;
    $display("errors %0d checks %0d", err_count, check_count);
    if (err_count == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : complete_run

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    void'($urandom(78501));
    repeat (5) @(posedge clock);
    nrst <= 1'b1;
    // Boundary operands and data, back to back, every dest and bank bit
    for (int i = 0; i < 16; i++) begin
      step(1'b1, {CIS_DEC_FILE_TOP, 1'(i), 1'(i >> 1), fVals[i >> 2]}, dVals[i >> 2]);
    end
    // Mixed traffic; a decrement offered in the call's dead slot must be dropped
    for (int i = 0; i < 80; i++) begin
      if ($urandom_range(3) == 0) begin
        step(1'b1, CIS_CALL_VIA_W_CODE, 8'($urandom));
        step(1'b1, {CIS_DEC_FILE_TOP, 10'($urandom)}, 8'($urandom));
        step(1'b0, 16'h0000, 8'h00);
      end else begin
        step(1'b1, {CIS_DEC_FILE_TOP, 10'($urandom)}, 8'($urandom));
      end
    end
    step(1'b0, 16'h0000, 8'h00);
    complete_run();
  end
endmodule : cpu_instruction_semantics_test
